// file: verilog/tsq_pkg.sv
`default_nettype none
package tsq_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CODES  = 8'h04;
  localparam logic [7:0] OFF_LOOP   = 8'h08;
  localparam logic [7:0] OFF_LOOPOP = 8'h0c;
  localparam logic [7:0] OFF_SLOTS  = 8'h10;
  localparam logic [7:0] OFF_CMD    = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // Field positions
  localparam int CTRL_FWD_BIT     = 0;
  localparam int CTRL_GPIO_BIT    = 1;
  localparam int CTRL_TTL_LSB     = 2;
  localparam int CODES_FWD_LSB    = 0;
  localparam int CODES_REV_LSB    = 4;
  localparam int LOOPOP_INC_BIT   = 0;
  localparam int LOOPOP_DEC_BIT   = 1;
  localparam int CMD_OP_LSB       = 0;
  localparam int CMD_SLOT_LSB     = 4;
  localparam int CMD_BIT_LSB      = 8;
  localparam int STAT_SLOT_LSB    = 0;
  localparam int STAT_TAKEN_BIT   = 4;
  localparam int STAT_REFUSED_BIT = 5;
  localparam int STAT_HELD_BIT    = 6;
  localparam int STAT_PASS_BIT    = 7;
  localparam int STAT_BUSY_BIT    = 8;

  // Widths and limits
  localparam int         CODE_W       = 3;
  localparam int         NUM_SLOTS    = 6;
  localparam int         PAR_IN_W     = 5;
  localparam logic [2:0] SLOT_MIN     = 3'h1;
  localparam logic [2:0] SLOT_MAX     = 3'h6;
  localparam logic [2:0] BIT_SEL_MAX  = 3'h4;

  // Reset values
  localparam logic [2:0] FWD_CODE_RST = 3'h7;
  localparam logic [2:0] REV_CODE_RST = 3'h0;
  localparam logic [2:0] SLOT_RST     = 3'h1;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int PULSE_NS      = 1000;
  localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CW      = $clog2(PULSE_CYC + 1);

  typedef enum logic [1:0] {TTL_HIGH, TTL_LOW, TTL_PULSE_HIGH, TTL_PULSE_LOW} tsq_ttl_mode_t;
  typedef enum logic [2:0] {OP_NONE, OP_JUMP, OP_PASS, OP_FAIL, OP_CNT_ZERO, OP_CNT_NZ, OP_BIT_HIGH,
                            OP_BIT_LOW} tsq_op_t;
  typedef enum logic [1:0] {STB_VALID, STB_HOLD, STB_SETTLE} tsq_stb_t;

endpackage
`default_nettype wire

// file: verilog/tsq_ttl_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tsq_ttl_if;
  tsq_pkg::tsq_ttl_mode_t mode;
  logic                   sweep_end;
  logic                   level;
  modport ctl (output mode, output sweep_end, input level);
  modport gen (input mode, input sweep_end, output level);
endinterface
`default_nettype wire

// file: verilog/tsq_ttl_out.sv
`timescale 1ns/10ps
`default_nettype none
module tsq_ttl_out (
  input  wire logic pclk,
  input  wire logic presetn,
  tsq_ttl_if.gen    ttl
);
  import tsq_pkg::*;

  typedef struct packed {
    logic                level;
    logic                busy;
    logic [PULSE_CW-1:0] cnt;
  } tsq_ttl_state_t;

  tsq_ttl_state_t s_reg;
  tsq_ttl_state_t s_next;

  always_comb begin
    s_next = s_reg;
    case (ttl.mode)
      TTL_HIGH: begin
        s_next.level = 1'b1;
        s_next.busy  = 1'b0;
      end
      TTL_LOW: begin
        s_next.level = 1'b0;
        s_next.busy  = 1'b0;
      end
      default: begin
        // Retrigger restarts the pulse rather than stretching it
        if (ttl.sweep_end) begin
          s_next.busy  = 1'b1;
          s_next.cnt   = PULSE_CW'(PULSE_CYC - 1);
          s_next.level = (ttl.mode == TTL_PULSE_HIGH);
        end else if (s_reg.busy && s_reg.cnt != '0) begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end else begin
          s_next.busy  = 1'b0;
          s_next.level = (ttl.mode == TTL_PULSE_LOW);
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{level: 1'b1, busy: 1'b0, cnt: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign ttl.level = s_reg.level;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pulse_hold: assert property (
    s_reg.busy && s_reg.cnt != '0 && ttl.mode == TTL_PULSE_HIGH |=> ttl.mode != TTL_PULSE_HIGH || ttl.level)
    else $error("End-of-sweep pulse ended early");
  a_pulse_start: assert property (
    ttl.mode == TTL_PULSE_LOW && ttl.sweep_end |=> !ttl.level [*8])
    else $error("Low pulse not driven at sweep end");
  a_static_level: assert property (
    ttl.mode == TTL_HIGH |=> ttl.level)
    else $error("Static high mode not high");
  c_pulse_high: cover property (ttl.mode == TTL_PULSE_HIGH && ttl.sweep_end);
endmodule
`default_nettype wire

// file: verilog/tsq_top.sv
// Operation
// - Code line two is high for fixture codes four through seven.
// - Code line one is high for codes two, three, six, seven.
// - Code line zero is high for odd fixture codes.
// - Valid strobe is low only while code lines are valid.
// - Direction line high for forward, low for reverse measurement.
// - New sweeps wait while the sweep-delay input is asserted.
// - Forward code resets to seven; six clears line zero, seven restores.
// - Sequencing TTL level is mirrored on a port line.
// - Limit-test result output is mirrored on a port line.
// - TTL output: static high, static low, high or low end-sweep pulse.
// - Decision commands jump one-way only when their condition holds.
// - Branch target is slot one to six, picked by its number.
// - Branch only to a slot that holds a sequence.
// - Jump to the running slot restarts it from its first command.
// - Input-bit decisions work only in general-purpose port mode.
// - Pass and fail decisions jump on the latest limit result.
// - Loop counter can be loaded, incremented and decremented.
// - Counter zero and nonzero decisions jump, possibly restarting itself.
// - Loop counter value is readable for title suffixes.
// - Separate forward and reverse codes; active direction picks output.
// - Input decision tests one selected port bit from zero to four.
`timescale 1ns/10ps
`default_nettype none
module tsq_top #(
  parameter int LOOP_W = 17
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [7:0]              paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic [tsq_pkg::CODE_W-1:0]   fixture_code,
  output logic                         fixture_valid_n,
  output logic                         fwd_indicator,
  input  wire logic                    sweep_delay,
  output logic                         ttl_seq_out,
  output logic                         ttl_seq_mirror,
  output logic                         limit_mirror,
  input  wire logic                    limit_out,
  input  wire logic                    limit_done,
  input  wire logic                    limit_pass,
  input  wire logic                    sweep_req,
  input  wire logic                    sweep_end,
  output logic                         sweep_go,
  input  wire logic [tsq_pkg::PAR_IN_W-1:0] par_in,
  output logic [2:0]                   exec_slot,
  output logic                         exec_restart
);
  import tsq_pkg::*;

  typedef struct packed {
    logic                  fwd;
    logic                  gpio;
    tsq_ttl_mode_t         ttl_mode;
    logic [CODE_W-1:0]     fwd_code;
    logic [CODE_W-1:0]     rev_code;
    logic [LOOP_W-1:0]     loop_cnt;
    logic [NUM_SLOTS-1:0]  slot_mask;
    logic [2:0]            exec_slot;
    logic                  restart;
    logic                  taken;
    logic                  refused;
    logic                  pending;
    logic                  go;
    logic                  held;
    logic                  limit_pass;
    logic                  limit_mirror;
    tsq_stb_t              stb;
    logic [CODE_W-1:0]     code_out;
    logic                  valid_n;
    logic [2:0]            bit_sel;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } tsq_state_t;

  tsq_state_t s_reg;
  tsq_state_t s_next;

  logic              wr_fire;
  logic              cmd_fire;
  tsq_op_t           cmd_op;
  logic [2:0]        cmd_slot;
  logic [2:0]        cmd_bit;
  logic              slot_ok;
  logic              bit_ok;
  logic              par_bit;
  logic              cond;
  logic [CODE_W-1:0] sel_code;

  tsq_ttl_if ttl_bus ();

  tsq_ttl_out u_ttl (
    .pclk    (pclk),
    .presetn (presetn),
    .ttl     (ttl_bus.gen)
  );

  assign ttl_bus.mode      = s_reg.ttl_mode;
  assign ttl_bus.sweep_end = sweep_end;

  // Write lands on the edge where the master samples pready high
  assign wr_fire  = psel && penable && pwrite && s_reg.pready && !s_reg.pslverr;
  assign cmd_fire = wr_fire && (paddr == OFF_CMD);
  assign cmd_op   = tsq_op_t'(pwdata[CMD_OP_LSB +: 3]);
  assign cmd_slot = pwdata[CMD_SLOT_LSB +: 3];
  assign cmd_bit  = pwdata[CMD_BIT_LSB +: 3];

  // Slot number, not title, selects the target
  assign slot_ok  = (cmd_slot >= SLOT_MIN) && (cmd_slot <= SLOT_MAX) &&
                    s_reg.slot_mask[cmd_slot - SLOT_MIN];
  assign bit_ok   = s_reg.gpio && (cmd_bit <= BIT_SEL_MAX);
  assign par_bit  = bit_ok ? par_in[cmd_bit] : 1'b0;

  always_comb begin
    case (cmd_op)
      OP_JUMP:     cond = 1'b1;
      OP_PASS:     cond = s_reg.limit_pass;
      OP_FAIL:     cond = !s_reg.limit_pass;
      OP_CNT_ZERO: cond = (s_reg.loop_cnt == '0);
      OP_CNT_NZ:   cond = (s_reg.loop_cnt != '0);
      OP_BIT_HIGH: cond = bit_ok && par_bit;
      OP_BIT_LOW:  cond = bit_ok && !par_bit;
      default:     cond = 1'b0;
    endcase
  end

  assign sel_code = s_reg.fwd ? s_reg.fwd_code : s_reg.rev_code;

  always_comb begin
    s_next         = s_reg;
    s_next.restart = 1'b0;
    s_next.go      = 1'b0;
    s_next.pready  = 1'b0;
    s_next.pslverr = 1'b0;

    s_next.limit_mirror = limit_out;
    if (limit_done) begin
      s_next.limit_pass = limit_pass;
    end

    // Sweep hold-off; a request arriving with the launch stays pending
    if (s_reg.pending && !sweep_delay) begin
      s_next.go      = 1'b1;
      s_next.pending = 1'b0;
    end
    if (sweep_req) begin
      s_next.pending = 1'b1;
    end
    s_next.held = sweep_delay && s_next.pending;

    // Strobe up, then lines change, then strobe down a cycle later
    case (s_reg.stb)
      STB_VALID: begin
        if (sel_code != s_reg.code_out) begin
          s_next.valid_n = 1'b1;
          s_next.stb     = STB_HOLD;
        end
      end
      STB_HOLD: begin
        s_next.code_out = sel_code;
        s_next.stb      = STB_SETTLE;
      end
      STB_SETTLE: begin
        s_next.valid_n = 1'b0;
        s_next.stb     = STB_VALID;
      end
      default: begin
        s_next.stb = STB_VALID;
      end
    endcase

    // Access phase, reads and writes: first access cycle computes ready, data and error
    if (psel && penable && !s_reg.pready) begin
      s_next.pready = 1'b1;
      s_next.prdata = '0;
      if (paddr == OFF_CTRL) begin
        s_next.prdata[CTRL_FWD_BIT]       = s_reg.fwd;
        s_next.prdata[CTRL_GPIO_BIT]      = s_reg.gpio;
        s_next.prdata[CTRL_TTL_LSB +: 2]  = s_reg.ttl_mode;
      end else if (paddr == OFF_CODES) begin
        s_next.prdata[CODES_FWD_LSB +: CODE_W] = s_reg.fwd_code;
        s_next.prdata[CODES_REV_LSB +: CODE_W] = s_reg.rev_code;
      end else if (paddr == OFF_LOOP) begin
        s_next.prdata[LOOP_W-1:0] = s_reg.loop_cnt;
      end else if (paddr == OFF_LOOPOP) begin
        s_next.prdata = '0;
      end else if (paddr == OFF_SLOTS) begin
        s_next.prdata[NUM_SLOTS-1:0] = s_reg.slot_mask;
      end else if (paddr == OFF_CMD) begin
        s_next.prdata[CMD_BIT_LSB +: 3] = s_reg.bit_sel;
      end else if (paddr == OFF_STATUS) begin
        s_next.prdata[STAT_SLOT_LSB +: 3]  = s_reg.exec_slot;
        s_next.prdata[STAT_TAKEN_BIT]      = s_reg.taken;
        s_next.prdata[STAT_REFUSED_BIT]    = s_reg.refused;
        s_next.prdata[STAT_HELD_BIT]       = s_reg.held;
        s_next.prdata[STAT_PASS_BIT]       = s_reg.limit_pass;
        s_next.prdata[STAT_BUSY_BIT]       = s_reg.valid_n;
      end else begin
        s_next.pslverr = 1'b1;
      end
    end

    if (wr_fire) begin
      if (paddr == OFF_CTRL) begin
        s_next.fwd      = pwdata[CTRL_FWD_BIT];
        s_next.gpio     = pwdata[CTRL_GPIO_BIT];
        s_next.ttl_mode = tsq_ttl_mode_t'(pwdata[CTRL_TTL_LSB +: 2]);
      end else if (paddr == OFF_CODES) begin
        s_next.fwd_code = pwdata[CODES_FWD_LSB +: CODE_W];
        s_next.rev_code = pwdata[CODES_REV_LSB +: CODE_W];
      end else if (paddr == OFF_LOOP) begin
        s_next.loop_cnt = pwdata[LOOP_W-1:0];
      end else if (paddr == OFF_LOOPOP) begin
        // Counter wraps at its width; software keeps it in range
        if (pwdata[LOOPOP_INC_BIT] && !pwdata[LOOPOP_DEC_BIT]) begin
          s_next.loop_cnt = s_reg.loop_cnt + 1'b1;
        end else if (pwdata[LOOPOP_DEC_BIT] && !pwdata[LOOPOP_INC_BIT]) begin
          s_next.loop_cnt = s_reg.loop_cnt - 1'b1;
        end
      end else if (paddr == OFF_SLOTS) begin
        s_next.slot_mask = pwdata[NUM_SLOTS-1:0];
      end else if (paddr == OFF_STATUS) begin
        if (pwdata[STAT_REFUSED_BIT]) begin
          s_next.refused = 1'b0;
        end
      end
    end

    // One-way jump: no return slot is kept
    if (cmd_fire && cmd_op != OP_NONE) begin
      s_next.bit_sel = cmd_bit;
      s_next.taken   = 1'b0;
      if (cond && slot_ok) begin
        s_next.exec_slot = cmd_slot;
        s_next.restart   = 1'b1;
        s_next.taken     = 1'b1;
      end else if ((cond && !slot_ok) ||
                   ((cmd_op == OP_BIT_HIGH || cmd_op == OP_BIT_LOW) && !bit_ok)) begin
        s_next.refused = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg              <= '0;
      s_reg.fwd          <= 1'b1;
      s_reg.ttl_mode     <= TTL_HIGH;
      s_reg.fwd_code     <= FWD_CODE_RST;
      s_reg.rev_code     <= REV_CODE_RST;
      s_reg.exec_slot    <= SLOT_RST;
      s_reg.stb          <= STB_VALID;
      s_reg.code_out     <= FWD_CODE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata          = s_reg.prdata;
  assign pready          = s_reg.pready;
  assign pslverr         = s_reg.pslverr;
  assign fixture_code    = s_reg.code_out;
  assign fixture_valid_n = s_reg.valid_n;
  assign fwd_indicator   = s_reg.fwd;
  assign ttl_seq_out     = ttl_bus.level;
  assign ttl_seq_mirror  = ttl_bus.level;
  assign limit_mirror    = s_reg.limit_mirror;
  assign sweep_go        = s_reg.go;
  assign exec_slot       = s_reg.exec_slot;
  assign exec_restart    = s_reg.restart;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_code_track: assert property (s_reg.stb == STB_HOLD |=> fixture_code == $past(sel_code))
    else $error("Code lines do not match active code");
  a_strobe_shape: assert property ($rose(fixture_valid_n) |-> fixture_valid_n ##1 fixture_valid_n ##1 !fixture_valid_n)
    else $error("Valid strobe sequence wrong");
  a_code_guarded: assert property ($changed(fixture_code) |-> fixture_valid_n && $past(fixture_valid_n))
    else $error("Code changed while strobe low");
  a_dir_follow: assert property (
    $changed(fwd_indicator) && s_reg.fwd_code != s_reg.rev_code && s_reg.stb == STB_VALID && !fixture_valid_n
    |=> fixture_valid_n)
    else $error("Direction change did not update code");
  a_sweep_hold: assert property (sweep_delay |=> !sweep_go)
    else $error("Sweep launched during hold-off");
  a_limit_copy: assert property (limit_mirror == $past(limit_out))
    else $error("Limit mirror lags");
  a_branch_take: assert property (cmd_fire && cmd_op != OP_NONE && cond && slot_ok
    |=> exec_restart && exec_slot == $past(cmd_slot))
    else $error("True decision did not jump");
  a_branch_empty: assert property (cmd_fire && !slot_ok |=> !exec_restart)
    else $error("Jump to empty slot");
  a_gpio_gate: assert property (cmd_fire && (cmd_op == OP_BIT_HIGH || cmd_op == OP_BIT_LOW) && !s_reg.gpio
    |=> !exec_restart)
    else $error("Input decision outside port mode");
  a_cnt_step: assert property (
    wr_fire && paddr == OFF_LOOPOP && pwdata[LOOPOP_DEC_BIT] && !pwdata[LOOPOP_INC_BIT]
    |=> s_reg.loop_cnt == LOOP_W'($past(s_reg.loop_cnt) - 1'b1))
    else $error("Loop counter decrement wrong");

  c_loop_self: cover property (cmd_fire && cmd_op == OP_CNT_NZ && cond && slot_ok && cmd_slot == s_reg.exec_slot);
  c_strobe: cover property ($rose(fixture_valid_n) ##2 !fixture_valid_n);
  c_sweep_wait: cover property (s_reg.pending && sweep_delay ##1 !sweep_delay ##1 sweep_go);
  c_limit_fail: cover property (cmd_fire && cmd_op == OP_FAIL && cond && slot_ok);
endmodule
`default_nettype wire

// file: test/tsq_handler_model.sv
`timescale 1ns/10ps
`default_nettype none
module tsq_handler_model #(
  parameter int BUSY_CYC = 20
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] fixture_code,
  input  wire logic       fixture_valid_n,
  input  wire logic       busy_start,
  output logic            sweep_delay,
  output logic [2:0]      latched_code,
  output int              strobe_viol
);
  int         busy_cnt;
  logic [2:0] prev_code;
  logic       prev_vn;

  // Own sweep keeps the analyzer waiting until it has finished
  assign sweep_delay = (busy_cnt != 0);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 0;
      strobe_viol <= 0;
      latched_code <= 3'h0;
      prev_code <= 3'h0;
      prev_vn <= 1'b1;
    end else begin
      if (busy_start) begin
        busy_cnt <= BUSY_CYC;
      end else if (busy_cnt > 0) begin
        busy_cnt <= busy_cnt - 1;
      end
      // Latch only on the low strobe, as a real handler would
      if (fixture_valid_n === 1'b0) begin
        latched_code <= fixture_code;
      end
      // A code change under a low strobe would be latched half-made
      if (fixture_valid_n === 1'b0 && prev_vn === 1'b0 && fixture_code !== prev_code) begin
        strobe_viol <= strobe_viol + 1;
      end
      prev_code <= fixture_code;
      prev_vn <= fixture_valid_n;
    end
  end
endmodule
`default_nettype wire

// file: test/tsq_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tsq_top_tb;
  import tsq_pkg::*;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  fixture_code;
  logic        fixture_valid_n;
  logic        fwd_indicator;
  logic        sweep_delay;
  logic        ttl_seq_out;
  logic        ttl_seq_mirror;
  logic        limit_mirror;
  logic        limit_out;
  logic        limit_done;
  logic        limit_pass;
  logic        sweep_req;
  logic        sweep_end;
  logic        sweep_go;
  logic [4:0]  par_in;
  logic [2:0]  exec_slot;
  logic        exec_restart;
  logic        busy_start;
  logic [2:0]  latched_code;
  int          strobe_viol;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          rst_cnt = 0;

  tsq_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fixture_code(fixture_code), .fixture_valid_n(fixture_valid_n), .fwd_indicator(fwd_indicator),
    .sweep_delay(sweep_delay), .ttl_seq_out(ttl_seq_out), .ttl_seq_mirror(ttl_seq_mirror),
    .limit_mirror(limit_mirror), .limit_out(limit_out), .limit_done(limit_done),
    .limit_pass(limit_pass), .sweep_req(sweep_req), .sweep_end(sweep_end), .sweep_go(sweep_go),
    .par_in(par_in), .exec_slot(exec_slot), .exec_restart(exec_restart));

  tsq_handler_model handler (.pclk(pclk), .presetn(presetn), .fixture_code(fixture_code),
    .fixture_valid_n(fixture_valid_n), .busy_start(busy_start), .sweep_delay(sweep_delay),
    .latched_code(latched_code), .strobe_viol(strobe_viol));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (exec_restart === 1'b1) begin
      rst_cnt <= rst_cnt + 1;
    end
  end

  task end_of_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
           output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (n >= 50) begin
      chk(32'h0, 32'h1);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b1, d, q, e);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(a, 1'b0, 32'h0, q, e);
  endtask

  task t_codes;
    logic [2:0] seq [9];
    logic [2:0] c;
    seq = '{3'h6, 3'h7, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    for (int i = 0; i < 9; i++) begin
      c = seq[i];
      wr(OFF_CODES, {29'h0, c});
      repeat (4) @(posedge pclk);
      chk({31'h0, fixture_code[2]}, {31'h0, c inside {3'h4, 3'h5, 3'h6, 3'h7}});
      chk({31'h0, fixture_code[1]}, {31'h0, c inside {3'h2, 3'h3, 3'h6, 3'h7}});
      chk({31'h0, fixture_code[0]}, {31'h0, c inside {3'h1, 3'h3, 3'h5, 3'h7}});
      chk({29'h0, latched_code}, {29'h0, c});
    end
    chk(32'(strobe_viol), 32'h0);
  endtask

  task t_dir;
    wr(OFF_CODES, 32'h35);
    wr(OFF_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
    chk({28'h0, fwd_indicator, fixture_code}, 32'h3);
    wr(OFF_CTRL, 32'h1);
    repeat (4) @(posedge pclk);
    chk({28'h0, fwd_indicator, fixture_code}, 32'hd);
  endtask

  task t_mirror;
    for (int v = 1; v >= 0; v--) begin
      limit_out <= 1'(v);
      repeat (2) @(posedge pclk);
      chk({31'h0, limit_mirror}, 32'(v));
    end
  endtask

  task t_ttl;
    int   act;
    int   mm;
    logic idle;
    for (int m = 0; m < 4; m++) begin
      idle = (m == 0 || m == 3);
      wr(OFF_CTRL, 32'(m << CTRL_TTL_LSB) | 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, ttl_seq_out}, {31'h0, idle});
      sweep_end <= 1'b1;
      @(posedge pclk);
      sweep_end <= 1'b0;
      act = 0;
      mm = 0;
      repeat (60) begin
        @(posedge pclk);
        if (ttl_seq_out !== idle) act++;
        if (ttl_seq_mirror !== ttl_seq_out) mm++;
      end
      chk(32'(act), (m >= 2) ? 32'(PULSE_CYC) : 32'h0);
      chk(32'(mm), 32'h0);
    end
  endtask

  task t_sweep;
    logic [31:0] q;
    int          n;
    busy_start <= 1'b1;
    @(posedge pclk);
    busy_start <= 1'b0;
    sweep_req <= 1'b1;
    @(posedge pclk);
    sweep_req <= 1'b0;
    rd(OFF_STATUS, q);
    chk({31'h0, q[STAT_HELD_BIT]}, 32'h1);
    n = 0;
    while (sweep_go !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk({30'h0, sweep_go, sweep_delay}, 32'h2);
  endtask

  // Sticky refusal is cleared first so each command is judged alone
  task cmd(input logic [2:0] op, input logic [2:0] sl, input logic [2:0] b, input logic [2:0] es,
           input logic et, input logic er);
    logic [31:0] q;
    int          r0;
    wr(OFF_STATUS, 32'h20);
    r0 = rst_cnt;
    wr(OFF_CMD, {21'h0, b, 1'b0, sl, 1'b0, op});
    repeat (2) @(posedge pclk);
    rd(OFF_STATUS, q);
    chk({26'h0, q[5:0]}, {26'h0, er, et, 1'b0, es});
    chk({29'h0, exec_slot}, {29'h0, es});
    chk(32'(rst_cnt - r0), {31'h0, et});
  endtask

  task t_branch;
    logic [31:0] q;
    logic        e;
    wr(OFF_SLOTS, 32'h1b);
    cmd(OP_JUMP, 3'h2, 3'h0, 3'h2, 1'b1, 1'b0);
    cmd(OP_JUMP, 3'h3, 3'h0, 3'h2, 1'b0, 1'b1);
    cmd(OP_JUMP, 3'h7, 3'h0, 3'h2, 1'b0, 1'b1);
    cmd(OP_JUMP, 3'h2, 3'h0, 3'h2, 1'b1, 1'b0);
    limit_pass <= 1'b1;
    limit_done <= 1'b1;
    @(posedge pclk);
    limit_done <= 1'b0;
    @(posedge pclk);
    rd(OFF_STATUS, q);
    chk({31'h0, q[STAT_PASS_BIT]}, 32'h1);
    cmd(OP_FAIL, 3'h1, 3'h0, 3'h2, 1'b0, 1'b0);
    cmd(OP_PASS, 3'h4, 3'h0, 3'h4, 1'b1, 1'b0);
    wr(OFF_LOOP, 32'h2);
    wr(OFF_LOOPOP, 32'h2);
    rd(OFF_LOOP, q);
    chk(q, 32'h1);
    wr(OFF_LOOPOP, 32'h1);
    wr(OFF_LOOPOP, 32'h3);
    rd(OFF_LOOP, q);
    chk(q, 32'h2);
    wr(OFF_LOOP, 32'h0);
    cmd(OP_CNT_NZ, 3'h1, 3'h0, 3'h4, 1'b0, 1'b0);
    cmd(OP_CNT_ZERO, 3'h5, 3'h0, 3'h5, 1'b1, 1'b0);
    wr(OFF_LOOP, 32'h1);
    cmd(OP_CNT_NZ, 3'h5, 3'h0, 3'h5, 1'b1, 1'b0);
    par_in <= 5'h04;
    cmd(OP_BIT_HIGH, 3'h1, 3'h2, 3'h5, 1'b0, 1'b1);
    wr(OFF_CTRL, 32'h3);
    cmd(OP_BIT_HIGH, 3'h1, 3'h2, 3'h1, 1'b1, 1'b0);
    cmd(OP_BIT_LOW, 3'h2, 3'h2, 3'h1, 1'b0, 1'b0);
    cmd(OP_BIT_LOW, 3'h2, 3'h0, 3'h2, 1'b1, 1'b0);
    cmd(OP_BIT_HIGH, 3'h4, 3'h5, 3'h2, 1'b0, 1'b1);
    apb(8'h1c, 1'b0, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
  endtask

  initial begin
    presetn = 1'b0;
    paddr = 8'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    limit_out = 1'b0;
    limit_done = 1'b0;
    limit_pass = 1'b0;
    sweep_req = 1'b0;
    sweep_end = 1'b0;
    par_in = 5'h00;
    busy_start = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({24'h0, fixture_code, fixture_valid_n, fwd_indicator, exec_slot}, 32'he9);
    t_codes;
    t_dir;
    t_mirror;
    t_ttl;
    t_sweep;
    t_branch;
    end_of_test;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #500000;
    error_cnt++;
    end_of_test;
  end
endmodule
`default_nettype wire
